// ---- rtl/modulator_pkg.sv ----
// constants, field layout and state codes of the modulator control bank
// assumes a 200 MHz core clock and bus pins sampled in that domain
package modulator_pkg;
  // bus address byte, write direction included
  localparam logic [7:0] DEV_ADDR     = 8'hCA;
  // power-on values of the four bytes
  localparam logic [7:0] CTRL1_RESET  = 8'h86;
  localparam logic [7:0] CTRL2_RESET  = 8'h08;
  localparam logic [7:0] DIVH_RESET   = 8'h24;
  localparam logic [7:0] DIVL_RESET   = 8'hF4;
  // field positions
  localparam int KIND_BIT  = 7;  // 1: control pair, 0: divider pair
  localparam int PSR_LSB   = 1;
  localparam int WCO_BIT   = 7;
  localparam int PSD_BIT   = 6;
  localparam int ACS_LSB   = 3;
  localparam int PGE_BIT   = 6;
  localparam int RSS_LSB   = 2;
  localparam int TEST_BIT  = 0;
  // pattern generator line timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int LINE_NS       = 64000;
  localparam int SYNC_NS       = 4000;
  localparam int WHITE_NS      = 4000;
  localparam int WHITE1_NS     = 24000;
  localparam int WHITE2_NS     = 40000;
  localparam int SYNC_CYCLES   = SYNC_NS / CLK_PERIOD_NS;
  localparam int WHITE_CYCLES  = WHITE_NS / CLK_PERIOD_NS;
  // bit count of one byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // bus receiver states, gray along idle-addr-ack-data-ack
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_DATA     = 3'b010,
    ST_DATA_ACK = 3'b110
  } bus_state_type;
endpackage : modulator_pkg

// ---- rtl/modulator_control.sv ----
// modulator control bank: bus write receiver, settings and test pattern timing
// assumes scl/sda come from the pins unsynchronised; sda is open drain
//
// Overview of operation
// - bit 0 of the low divider byte set to 1 selects test mode and 0 selects normal mode.
// - after power-up reset the defaults stay until the first data byte is accepted.
// - until then power saving is on and the rf output is muted.
// - the carrier divider resets to 591 so the oscillator aims at 591.25 MHz.
// - the audio carrier field resets to 5.5 MHz with 50 kHz deviation.
// - reset also gives internal reference, -13dB ratio, white clip on, pattern off, normal mode.
// - an enabled pattern gives a 4.0 us sync pulse every 64 us.
// - each white pulse of the pattern lasts 4.0 us.
// - white pulses start 24 us and 40 us after the sync start.
// - address byte 11001010 is acknowledged and either pair, or both in either order, is taken.
// - power save disable written 0 powers down all but the bus logic and keeps the settings; here the pattern generator keeps running.
// - the rf target is 1 MHz times the ten-bit divider plus a fixed 250 kHz.
// - reference select 00 is external, 01 crystal, upper bit set is test mode.
`timescale 1ns/1ps
module modulator_control
  import modulator_pkg::*;
#(
  parameter int LINE_CYCLES   = LINE_NS / CLK_PERIOD_NS,
  parameter int WHITE1_CYCLES = WHITE1_NS / CLK_PERIOD_NS,
  parameter int WHITE2_CYCLES = WHITE2_NS / CLK_PERIOD_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            power_save_active,
  output logic            rf_output_enable,
  output logic            white_clip_off,
  output logic [2:0]      picture_sound_ratio,
  output logic [1:0]      audio_carrier_select,
  output logic [9:0]      carrier_divider,
  output logic [1:0]      reference_source_select,
  output logic            test_mode,
  output logic            pattern_generator_enable,
  output logic            pattern_sync,
  output logic            pattern_white
);

  // true while cnt lies in [start, start+len)
  function automatic logic in_window(input logic [15:0] cnt, input int start, input int len);
    in_window = (cnt >= 16'(start)) && (cnt < 16'(start + len));
  endfunction : in_window

  logic [2:0]    scl_sync_reg;
  logic [2:0]    sda_sync_reg;
  bus_state_type state_reg, state_next;
  logic [3:0]    bit_cnt_reg, bit_cnt_next;
  logic [7:0]    shift_reg, shift_next;
  logic          second_reg, second_next;
  logic          kind_reg, kind_next;
  logic          oe_reg, oe_next;
  logic          configured_reg, configured_next;
  logic [7:0]    ctrl1_reg, ctrl1_next;
  logic [7:0]    ctrl2_reg, ctrl2_next;
  logic [7:0]    divh_reg, divh_next;
  logic [7:0]    divl_reg, divl_next;
  logic          psave_reg, psave_next;
  logic          rf_en_reg, rf_en_next;
  logic [15:0]   line_cnt_reg, line_cnt_next;
  logic          sync_reg, sync_next;
  logic          white_reg, white_next;
  logic          scl_rise, scl_fall, bus_start, bus_stop;
  logic          commit;

  // two-stage synchronisers plus one history stage for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  // bus events from the synchronised stages only
  assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign bus_start = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
  assign bus_stop  = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
  // a data byte lands when its acknowledge clock ends
  assign commit    = (state_reg == ST_DATA_ACK) && scl_fall;

  // bus receiver and register writes
  always_comb begin
    state_next      = state_reg;
    bit_cnt_next    = bit_cnt_reg;
    shift_next      = shift_reg;
    second_next     = second_reg;
    kind_next       = kind_reg;
    oe_next         = oe_reg;
    configured_next = configured_reg;
    ctrl1_next      = ctrl1_reg;
    ctrl2_next      = ctrl2_reg;
    divh_next       = divh_reg;
    divl_next       = divl_reg;
    if (bus_start) begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'h0;
      second_next  = 1'b0;
      oe_next      = 1'b0;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          oe_next = 1'b0;
        end
        ST_ADDR, ST_DATA: begin
          if (scl_rise && bit_cnt_reg != BYTE_BITS) begin
            shift_next   = {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
            if (state_reg == ST_DATA) begin
              state_next = ST_DATA_ACK;
              oe_next    = 1'b1;
            end else if (shift_reg == DEV_ADDR) begin
              state_next = ST_ADDR_ACK;
              oe_next    = 1'b1;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            state_next   = ST_DATA;
            oe_next      = 1'b0;
            bit_cnt_next = 4'h0;
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
    // first byte of a pair picks the pair by its top bit, the second completes it
    if (commit) begin
      configured_next = 1'b1;
      second_next     = ~second_reg;
      if (!second_reg) begin
        kind_next = shift_reg[KIND_BIT];
        if (shift_reg[KIND_BIT]) begin
          ctrl1_next = shift_reg;
        end else begin
          divh_next = shift_reg;
        end
      end else if (kind_reg) begin
        ctrl2_next = shift_reg;
      end else begin
        divl_next = shift_reg;
      end
    end
  end

  // power state: muted until configured, then follows the disable bit
  always_comb begin
    psave_next = ~configured_reg | ~ctrl2_reg[PSD_BIT];
    rf_en_next = configured_reg & ctrl2_reg[PSD_BIT];
  end

  // pattern line counter and pulse decode
  always_comb begin
    line_cnt_next = 16'h0000;
    sync_next     = 1'b0;
    white_next    = 1'b0;
    if (divh_reg[PGE_BIT]) begin
      if (line_cnt_reg != 16'(LINE_CYCLES - 1)) begin
        line_cnt_next = line_cnt_reg + 16'h0001;
      end
      sync_next  = in_window(line_cnt_reg, 0, SYNC_CYCLES);
      white_next = in_window(line_cnt_reg, WHITE1_CYCLES, WHITE_CYCLES)
                 | in_window(line_cnt_reg, WHITE2_CYCLES, WHITE_CYCLES);
    end
  end

  // state registers; settings reset to the power-on configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      second_reg     <= 1'b0;
      kind_reg       <= 1'b0;
      oe_reg         <= 1'b0;
      configured_reg <= 1'b0;
      ctrl1_reg      <= CTRL1_RESET;
      ctrl2_reg      <= CTRL2_RESET;
      divh_reg       <= DIVH_RESET;
      divl_reg       <= DIVL_RESET;
      psave_reg      <= 1'b1;
      rf_en_reg      <= 1'b0;
      line_cnt_reg   <= 16'h0000;
      sync_reg       <= 1'b0;
      white_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      bit_cnt_reg    <= bit_cnt_next;
      shift_reg      <= shift_next;
      second_reg     <= second_next;
      kind_reg       <= kind_next;
      oe_reg         <= oe_next;
      configured_reg <= configured_next;
      ctrl1_reg      <= ctrl1_next;
      ctrl2_reg      <= ctrl2_next;
      divh_reg       <= divh_next;
      divl_reg       <= divl_next;
      psave_reg      <= psave_next;
      rf_en_reg      <= rf_en_next;
      line_cnt_reg   <= line_cnt_next;
      sync_reg       <= sync_next;
      white_reg      <= white_next;
    end
  end

  // outputs other than sda_out (tied to 0) are register bits; rf target is divider MHz plus 250 kHz
  assign sda_out                  = 1'b0;
  assign sda_oe                   = oe_reg;
  assign power_save_active        = psave_reg;
  assign rf_output_enable         = rf_en_reg;
  assign white_clip_off           = ctrl2_reg[WCO_BIT];
  assign picture_sound_ratio      = ctrl1_reg[PSR_LSB +: 3];
  assign audio_carrier_select     = ctrl2_reg[ACS_LSB +: 2];
  assign carrier_divider          = {divh_reg[5:0], divl_reg[7:4]};
  assign reference_source_select  = divl_reg[RSS_LSB +: 2];
  assign test_mode                = divl_reg[TEST_BIT];
  assign pattern_generator_enable = divh_reg[PGE_BIT];
  assign pattern_sync             = sync_reg;
  assign pattern_white            = white_reg;

  // test mode follows a low divider byte one cycle after the byte lands
  sequence s_divl_commit;
    commit && second_reg && !kind_reg;
  endsequence
  property p_test_mode;
    @(posedge clk) disable iff (!rst_n)
      s_divl_commit |=> test_mode == $past(shift_reg[TEST_BIT]);
  endproperty
  a_test_mode: assert property (p_test_mode) else $error("test mode not taken");

  property p_defaults;
    @(posedge clk) $past(!rst_n) && rst_n |-> carrier_divider == 10'h24F
      && audio_carrier_select == 2'h1 && picture_sound_ratio == 3'h3
      && reference_source_select == 2'h1 && !white_clip_off && !test_mode
      && !pattern_generator_enable;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad reset defaults");

  property p_muted;
    @(posedge clk) disable iff (!rst_n)
      !configured_reg |=> power_save_active && !rf_output_enable;
  endproperty
  a_muted: assert property (p_muted) else $error("rf not muted");

  property p_power_save;
    @(posedge clk) disable iff (!rst_n)
      configured_reg && !ctrl2_reg[PSD_BIT] |=> power_save_active && !rf_output_enable;
  endproperty
  a_power_save: assert property (p_power_save) else $error("power save ignored");

  property p_sync_width;
    @(posedge clk) disable iff (!rst_n)
      $fell(pattern_sync) && pattern_generator_enable
        |-> $past(line_cnt_reg) == 16'(SYNC_CYCLES);
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync width wrong");

  property p_line_wrap;
    @(posedge clk) disable iff (!rst_n)
      pattern_generator_enable && line_cnt_reg == 16'(LINE_CYCLES - 1)
        |=> line_cnt_reg == 16'h0000 ##1 pattern_sync == $past(pattern_generator_enable);
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line period wrong");

  property p_white_start;
    @(posedge clk) disable iff (!rst_n)
      $rose(pattern_white) |-> $past(line_cnt_reg) == 16'(WHITE1_CYCLES)
        || $past(line_cnt_reg) == 16'(WHITE2_CYCLES);
  endproperty
  a_white_start: assert property (p_white_start) else $error("white start wrong");

  property p_white_end;
    @(posedge clk) disable iff (!rst_n)
      $fell(pattern_white) && pattern_generator_enable
        |-> $past(line_cnt_reg) == 16'(WHITE1_CYCLES + WHITE_CYCLES)
        || $past(line_cnt_reg) == 16'(WHITE2_CYCLES + WHITE_CYCLES);
  endproperty
  a_white_end: assert property (p_white_end) else $error("white width wrong");

  sequence s_addr_done;
    state_reg == ST_ADDR && scl_fall && bit_cnt_reg == BYTE_BITS && !bus_start && !bus_stop;
  endsequence
  property p_addr_ack;
    @(posedge clk) disable iff (!rst_n)
      s_addr_done |=> sda_oe == ($past(shift_reg) == DEV_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");

endmodule : modulator_control

// ---- verification/i2c_host_model.sv ----
// host bus controller model: start, stop and byte writes with ack sampling
// assumes the bench resolves the pulled-up data line and supplies clk
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_host
);
  int q = 20;  // clocks per bus phase, raised for a slow host
  // bus idle: both lines released high
  initial begin
    scl      = 1'b1;
    sda_host = 1'b1;
  end
  // one bus phase of idle clocks
  task automatic hold_q;
    repeat (q) @(posedge clk);
  endtask : hold_q
  // start: data falls while the clock is high
  task automatic start_cond;
    @(posedge clk);
    sda_host <= 1'b0;
    hold_q();
    scl <= 1'b0;
    hold_q();
  endtask : start_cond
  // one bit: data set with clock low, line sampled while clock is high
  task automatic clock_bit(input logic b, output logic seen);
    sda_host <= b;
    hold_q();
    scl <= 1'b1;
    hold_q();
    seen = sda_line;
    scl <= 1'b0;
    hold_q();
  endtask : clock_bit
  // eight bits msb first, then the ack clock with data released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  // stop: data rises while the clock is high
  task automatic stop_cond;
    sda_host <= 1'b0;
    hold_q();
    scl <= 1'b1;
    hold_q();
    sda_host <= 1'b1;
    hold_q();
  endtask : stop_cond
endmodule : i2c_host_model

// ---- verification/tb.sv ----
// self-checking bench of the modulator control bank
// assumes the host model drives the bus and the data line is pulled up
`timescale 1ns/1ps
module tb
  import modulator_pkg::*;
;
  localparam int LINE = 3200;
  localparam int W1   = 1000;
  localparam int W2   = 2000;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl, sda_host, sda_out, sda_oe, sda_line;
  logic       power_save_active, rf_output_enable, white_clip_off, test_mode;
  logic       pattern_generator_enable, pattern_sync, pattern_white;
  logic [2:0] picture_sound_ratio;
  logic [1:0] audio_carrier_select, reference_source_select;
  logic [9:0] carrier_divider;
  int         err_count = 0;
  int         n_checks = 0;
  // clock and open-drain data line with pull-up
  always #2.5 clk = ~clk;
  assign sda_line = sda_host & ~(sda_oe & ~sda_out);
  i2c_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_host(sda_host));
  modulator_control #(.LINE_CYCLES(LINE), .WHITE1_CYCLES(W1), .WHITE2_CYCLES(W2)) dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_save_active(power_save_active),
    .rf_output_enable(rf_output_enable), .white_clip_off(white_clip_off),
    .picture_sound_ratio(picture_sound_ratio), .audio_carrier_select(audio_carrier_select),
    .carrier_divider(carrier_divider), .reference_source_select(reference_source_select),
    .test_mode(test_mode), .pattern_generator_enable(pattern_generator_enable),
    .pattern_sync(pattern_sync), .pattern_white(pattern_white));
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // reset held for 20 clocks with the bus idle
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset
  // one write frame: address then n data bytes, acks compared
  task automatic frame(input logic [7:0] a, b0, b1, b2, b3, input int n, input logic ak);
    logic [7:0] d[4];
    logic       k;
    d = '{b0, b1, b2, b3};
    host.start_cond();
    host.send_byte(a, k);
    check("addr ack", k, ak);
    for (int i = 0; i < n; i++) begin
      host.send_byte(d[i], k);
      check("data ack", k, ak);
    end
    host.stop_cond();
    repeat (8) @(posedge clk);
    #1;
  endtask : frame
  // all setting outputs against expected values
  task automatic expect_cfg(input logic [2:0] r, input logic [1:0] au, input logic [9:0] n,
                            input logic [1:0] rs, input logic wc, tm, pg, pa, rf);
    check("ratio", picture_sound_ratio, r);
    check("audio", audio_carrier_select, au);
    check("divider", carrier_divider, n);
    check("refsel", reference_source_select, rs);
    check("clip off", white_clip_off, wc);
    check("test", test_mode, tm);
    check("pattern", pattern_generator_enable, pg);
    check("power save", power_save_active, pa);
    check("rf on", rf_output_enable, rf);
  endtask : expect_cfg
  // power-on state
  task automatic t_defaults;
    expect_cfg(3'h3, 2'h1, 10'h24F, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    check("lines", {sda_oe, pattern_sync, pattern_white}, 3'h0);
    $display("test defaults done");
  endtask : t_defaults
  // foreign address and read direction ignored
  task automatic t_bad_addr;
    frame(8'hC8, 8'h80, 8'h00, 8'h00, 8'h00, 2, 1'b0);
    frame(8'hCB, 8'h00, 8'h00, 8'h00, 8'h00, 1, 1'b0);
    expect_cfg(3'h3, 2'h1, 10'h24F, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test bad address done");
  endtask : t_bad_addr
  // both pair orders, don't care bits set, test mode on then off
  task automatic t_orders;
    frame(8'hCA, 8'hFB, 8'hD7, 8'h15, 8'hA5, 4, 1'b1);
    expect_cfg(3'h5, 2'h2, 10'h15A, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    frame(8'hCA, 8'h15, 8'hA0, 8'h81, 8'h00, 4, 1'b1);
    expect_cfg(3'h0, 2'h0, 10'h15A, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test pair orders done");
  endtask : t_orders
  // every reference and audio code
  task automatic t_codes;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      frame(8'hCA, {5'h10, c, 1'b0}, {3'h2, c, 3'h0}, 8'h3F, {4'h0, c, 2'h0}, 4, 1'b1);
      expect_cfg({1'b0, c}, c, 10'h3F0, c, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    $display("test codes done");
  endtask : t_codes
  // pattern line timing, written by a slow host
  task automatic t_pattern;
    int   c, sf, nr;
    int   wr[$], wf[$];
    logic ps, pw;
    host.q = 60;
    frame(8'hCA, 8'h49, 8'h14, 8'h00, 8'h00, 2, 1'b1);
    host.q = 20;
    c = 0;
    while (pattern_sync === 1'b1 && c < LINE) begin
      @(posedge clk);
      #1;
      c++;
    end
    while (pattern_sync !== 1'b1 && c < 2 * LINE) begin
      @(posedge clk);
      #1;
      c++;
    end
    ps = 1'b1;
    pw = pattern_white;
    sf = 0;
    nr = 0;
    for (c = 1; c <= LINE + 50; c++) begin
      @(posedge clk);
      #1;
      if (ps && !pattern_sync) sf = c;
      if (!ps && pattern_sync && nr == 0) nr = c;
      if (!pw && pattern_white) wr.push_back(c);
      if (pw && !pattern_white) wf.push_back(c);
      ps = pattern_sync;
      pw = pattern_white;
    end
    check("sync width", sf, SYNC_CYCLES);
    check("line", nr, LINE);
    check("white count", wr.size(), 2);
    check("white1 start", wr[0], W1);
    check("white2 start", wr[1], W2);
    check("white1 width", wf[0] - wr[0], WHITE_CYCLES);
    check("white2 width", wf[1] - wr[1], WHITE_CYCLES);
    frame(8'hCA, 8'h09, 8'h14, 8'h00, 8'h00, 2, 1'b1);
    check("pattern off", {pattern_sync, pattern_white, pattern_generator_enable}, 3'h0);
    $display("test pattern done");
  endtask : t_pattern
  // stimulus sequence, ending with a second reset
  initial begin
    do_reset();
    t_defaults();
    t_bad_addr();
    t_orders();
    t_codes();
    t_pattern();
    do_reset();
    t_defaults();
    close_out();
  end
  // watchdog against a hung bus
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule : tb
